// File: hw/pds_sequencer.sv
// boost gate-drive sequencer: pulse start/end, blanking, fault count, timers, load gating
// assumes comparator inputs are asynchronous levels and software uses AXI4-Lite
//
// Contract
// R1 - boost pull-up on as soon as the stage is enabled
// R2 - hard overvoltage ends the pulse now and blocks further pulses
// R3 - soft overvoltage engages in its band, releases at regulation
// R4 - current limit ignored for 325 ns blanking, then ends the pulse
// R5 - short-circuit comparator uses 175 ns blanking
// R6 - four consecutive short-circuit trips latch the fault state
// R7 - a pulse without short-circuit trip clears the trip count
// R8 - a short-circuit trip lengthens the restart watchdog to 1 ms
// R9 - zero-current detect arms on high crossing, triggers on low crossing
// R10 - restart watchdog starts a pulse after 200 us without trigger
// R11 - restart watchdog count restarts at every pulse start
// R12 - restart watchdog held off during hard overvoltage or shorted feedback
// R13 - no new pulse until the frequency clamp timer expires
// R14 - after clamp expiry wait for a zero-current trigger
// R15 - 10 us timeout starts a pulse, restarted at every zero-current event
// R16 - load enable/disable logic idle until flyback soft-start ends
// R17 - load below reference runs a selectable disable timer
// R18 - load above reference plus hysteresis for 100 us enables the stage
// R19 - skip suppresses pulses below threshold, resumes above threshold plus hysteresis
// R20 - skip disabled in start-up and undervoltage, allowed after regulation
// R21 - on-time comparator ends each pulse
// R22 - comparators synchronised, timers count block clock cycles
// R23 - latched fault holds the gate low until reset
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.

`timescale 1ns/1ps

module pds_sequencer #(
  parameter int unsigned WDOG_CYC    = pds_pkg::WDOG_US * pds_pkg::CLK_MHZ,
  parameter int unsigned EXT_CYC     = pds_pkg::EXT_WDOG_MS * pds_pkg::CLK_KHZ,
  parameter int unsigned EN_FILT_CYC = pds_pkg::EN_FILT_US * pds_pkg::CLK_MHZ,
  parameter int unsigned DIS0_CYC    = pds_pkg::DIS0_MS * pds_pkg::CLK_KHZ,
  parameter int unsigned DIS1_CYC    = pds_pkg::DIS1_S * pds_pkg::MS_PER_S * pds_pkg::CLK_KHZ,
  parameter int unsigned DIS2_CYC    = pds_pkg::DIS2_S * pds_pkg::MS_PER_S * pds_pkg::CLK_KHZ
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        s_axi_awvalid,
  output wire logic                        s_axi_awready,
  input  wire logic [pds_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_wvalid,
  output wire logic                        s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output wire logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output wire logic [1:0]                  s_axi_bresp,
  input  wire logic                        s_axi_arvalid,
  output wire logic                        s_axi_arready,
  input  wire logic [pds_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  output wire logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output wire logic [31:0]                 s_axi_rdata,
  output wire logic [1:0]                  s_axi_rresp,
  input  wire logic                        hard_ovp_cmp,
  input  wire logic                        soft_ovp_band_cmp,
  input  wire logic                        regulation_cmp,
  input  wire logic                        feedback_short_cmp,
  input  wire logic                        current_limit_cmp,
  input  wire logic                        short_circuit_cmp,
  input  wire logic                        zero_cross_arm_cmp,
  input  wire logic                        zero_cross_trigger_cmp,
  input  wire logic                        on_time_cmp,
  input  wire logic                        load_low_cmp,
  input  wire logic                        load_high_cmp,
  input  wire logic                        skip_low_cmp,
  input  wire logic                        skip_high_cmp,
  input  wire logic                        undervoltage_cmp,
  input  wire logic                        flyback_ss_done,
  output wire logic                        boost_gate_drive,
  output wire logic                        boost_pullup_en,
  output wire logic                        soft_ovp_en,
  output wire logic                        skip_active,
  output wire logic                        stage_enabled,
  output wire logic                        fault_latched
);
  import pds_pkg::*;

  // ***********************************************
  // state
  // ***********************************************
  typedef enum logic [1:0] {ST_IDLE, ST_OFF, ST_ON, ST_FAULT} pds_state_t;

  typedef struct packed {
    logic [N_IN-1:0]   sy1;
    logic [N_IN-1:0]   sy2;
    pds_state_t        state;
    logic              gate;
    logic [SHT_W-1:0]  blank;
    logic [SHT_W-1:0]  clamp;
    logic [SHT_W-1:0]  tout;
    logic [CNT_W-1:0]  wdog;
    logic [CNT_W-1:0]  dis;
    logic [CNT_W-1:0]  en;
    logic              wdog_ext;
    logic              zarm;
    logic              sc_hit;
    logic [SCC_W-1:0]  sc_cnt;
    logic              fault;
    logic              stage_en;
    logic              reached;
    logic              soft_ovp;
    logic              skip;
    logic              boost;
    logic [CTRL_W-1:0] ctrl;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } pds_regs_t;

  pds_regs_t        q;
  pds_regs_t        d;
  logic [N_IN-1:0]  raw;
  logic [N_IN-1:0]  s;
  logic             active;
  logic             zcd_trig;
  logic             zcd_evt;
  logic             clamp_done;
  logic             wdog_run;
  logic             wdog_exp;
  logic             tout_exp;
  logic             start;
  logic             ilim_trip;
  logic             sc_trip;
  logic             pulse_end;
  logic             sc_now;
  logic [CNT_W-1:0] wdog_lim;

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // long disable periods dominate the counter width; 13 s still fits 31 bits
  function automatic logic [CNT_W-1:0] dis_limit(input logic [1:0] sel);
    if (sel == 2'h0) begin
      dis_limit = CNT_W'(DIS0_CYC);
    end else if (sel == 2'h1) begin
      dis_limit = CNT_W'(DIS1_CYC);
    end else begin
      dis_limit = CNT_W'(DIS2_CYC);
    end
  endfunction

  assign raw = {flyback_ss_done, undervoltage_cmp, skip_high_cmp, skip_low_cmp,
                load_high_cmp, load_low_cmp, on_time_cmp, zero_cross_trigger_cmp,
                zero_cross_arm_cmp, short_circuit_cmp, current_limit_cmp,
                feedback_short_cmp, regulation_cmp, soft_ovp_band_cmp, hard_ovp_cmp};
  assign s = q.sy2;                                                    // R22

  // ***********************************************
  // pulse sequencing terms
  // ***********************************************
  assign active     = q.ctrl[CTRL_EN] && q.stage_en && !q.fault;
  assign zcd_trig   = q.zarm && s[IN_ZTRIG];                           // R9
  assign zcd_evt    = zcd_trig || s[IN_ZARM];
  assign clamp_done = (q.clamp == '0);
  assign wdog_run   = !s[IN_HOVP] && !s[IN_FBSH];                      // R12
  assign wdog_lim   = q.wdog_ext ? CNT_W'(EXT_CYC) : CNT_W'(WDOG_CYC); // R8
  assign wdog_exp   = wdog_run && (q.wdog >= wdog_lim);                // R10
  assign tout_exp   = clamp_done && (q.tout >= SHT_W'(TOUT_CYC));      // R15
  assign start      = (q.state == ST_OFF) && active && clamp_done && !s[IN_HOVP] // R13
                      && !q.skip && (zcd_trig || wdog_exp || tout_exp); // R14 R19
  assign ilim_trip  = s[IN_ILIM] && (q.blank >= SHT_W'(LIMIT_BLANK_CYC)); // R4
  assign sc_trip    = s[IN_SC] && (q.blank >= SHT_W'(SHORT_BLANK_CYC));   // R5
  assign pulse_end  = (q.state == ST_ON) && (s[IN_HOVP] || s[IN_ONT]    // R2 R21
                      || ilim_trip || sc_trip || !active);
  assign sc_now     = q.sc_hit || sc_trip;

  always_comb begin
    d     = q;
    d.sy1 = raw;
    d.sy2 = q.sy1;                                                     // R22

    // ***********************************************
    // regulation, boost, soft overvoltage, skip
    // ***********************************************
    if (!active) begin
      d.reached = 1'b0;
    end else if (s[IN_REG]) begin
      d.reached = 1'b1;
    end
    d.boost = active && (!d.reached || s[IN_UVP]);                     // R1
    if (s[IN_OVPB]) begin
      d.soft_ovp = active;                                             // R3
    end else if (s[IN_REG] || !active) begin
      d.soft_ovp = 1'b0;                                               // R3
    end
    // skip only once regulation is reached and never under undervoltage
    if (!d.reached || s[IN_UVP]) begin
      d.skip = 1'b0;                                                   // R20
    end else if (s[IN_SKLOW]) begin
      d.skip = 1'b1;                                                   // R19
    end else if (s[IN_SKHIGH]) begin
      d.skip = 1'b0;                                                   // R19
    end

    // ***********************************************
    // load-based disable and enable
    // ***********************************************
    if (!s[IN_SSDONE]) begin
      d.dis = '0;                                                      // R16
      d.en  = '0;                                                      // R16
    end else if (q.stage_en) begin
      d.en = '0;
      if (!s[IN_LLOW]) begin
        d.dis = '0;
      end else if (q.dis >= dis_limit(q.ctrl[CTRL_DIS_LSB +: 2])) begin
        d.dis      = '0;                                               // R17
        d.stage_en = 1'b0;                                             // R17
      end else begin
        d.dis = q.dis + 1'b1;                                          // R17
      end
    end else begin
      d.dis = '0;
      if (!s[IN_LHIGH]) begin
        d.en = '0;
      end else if (q.en >= CNT_W'(EN_FILT_CYC)) begin
        d.en       = '0;                                               // R18
        d.stage_en = 1'b1;                                             // R18
      end else begin
        d.en = q.en + 1'b1;                                            // R18
      end
    end

    // ***********************************************
    // gate sequencing
    // ***********************************************
    if (q.clamp != '0) begin
      d.clamp = q.clamp - 1'b1;                                        // R13
    end
    case (q.state)
      ST_IDLE: begin
        d.gate = 1'b0;
        d.wdog = '0;
        d.tout = '0;
        d.zarm = 1'b0;
        if (active) begin
          d.state = ST_OFF;
        end
      end
      ST_OFF: begin
        d.gate = 1'b0;
        d.wdog = wdog_run ? q.wdog + 1'b1 : '0;                        // R12
        if (s[IN_ZARM]) begin
          d.zarm = 1'b1;                                               // R9
        end else if (zcd_trig && !clamp_done) begin
          d.zarm = 1'b0;                                               // R14
        end
        // timeout restarts on every zero-current event
        if (zcd_evt || !clamp_done) begin
          d.tout = '0;                                                 // R15
        end else if (!tout_exp) begin
          d.tout = q.tout + 1'b1;                                      // R15
        end
        if (!active) begin
          d.state = ST_IDLE;
        end else if (start) begin
          d.state  = ST_ON;
          d.gate   = 1'b1;
          d.blank  = '0;
          d.sc_hit = 1'b0;
          d.wdog   = '0;                                               // R11
          d.tout   = '0;
          d.zarm   = 1'b0;
          d.clamp  = q.ctrl[CTRL_CLAMP] ? SHT_W'(CLAMP_HI_CYC)         // R13
                                        : SHT_W'(CLAMP_LO_CYC);
        end
      end
      ST_ON: begin
        d.wdog = '0;
        if (q.blank != '1) begin
          d.blank = q.blank + 1'b1;
        end
        if (pulse_end) begin
          d.gate  = 1'b0;                                              // R2 R4 R21
          d.state = active ? ST_OFF : ST_IDLE;
          if (sc_now) begin
            d.wdog_ext = 1'b1;                                         // R8
            d.sc_cnt   = q.sc_cnt + 1'b1;                              // R6
            if (q.sc_cnt == SCC_W'(SC_LIMIT - 1)) begin
              d.fault = 1'b1;                                          // R6
              d.state = ST_FAULT;
            end
          end else begin
            d.sc_cnt   = '0;                                           // R7
            d.wdog_ext = 1'b0;
          end
        end else if (sc_trip) begin
          d.sc_hit = 1'b1;
        end
      end
      default: begin
        d.gate = 1'b0;                                                 // R23
      end
    endcase

    // ***********************************************
    // axi4-lite slave
    // ***********************************************
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_SLVERR;
      if (hit(q.awaddr, CTRL_OFS)) begin
        d.bresp = RESP_OKAY;
        if (q.wstrb[0]) begin
          d.ctrl = q.wdata[CTRL_W-1:0];
        end
      end else if (hit(q.awaddr, STATUS_OFS)) begin
        d.bresp = RESP_OKAY;
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      if (hit(s_axi_araddr, CTRL_OFS)) begin
        d.rdata[CTRL_W-1:0] = q.ctrl;
      end else if (hit(s_axi_araddr, STATUS_OFS)) begin
        d.rdata[10:0] = {q.reached, q.wdog_ext, q.boost, q.soft_ovp, q.skip,
                         q.sc_cnt, q.fault, q.stage_en, q.gate};
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.stage_en <= 1'b1;
      q.ctrl     <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign s_axi_awready    = !q.aw_got && !q.bvalid;
  assign s_axi_wready     = !q.w_got && !q.bvalid;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_arready    = !q.rvalid;
  assign s_axi_rvalid     = q.rvalid;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign boost_gate_drive = q.gate;
  assign boost_pullup_en  = q.boost;
  assign soft_ovp_en      = q.soft_ovp;
  assign skip_active      = q.skip;
  assign stage_enabled    = q.stage_en;
  assign fault_latched    = q.fault;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sc_last_trip;
    (q.state == ST_ON) && pulse_end && sc_now && (q.sc_cnt == SCC_W'(SC_LIMIT - 1));
  endsequence

  sequence s_latched_low;
    q.fault && !q.gate;
  endsequence

  property p_hard_ovp_stop;
    s[IN_HOVP] |=> !q.gate ##1 (!q.gate || !$past(s[IN_HOVP]));
  endproperty
  a_hard_ovp_stop: assert property (p_hard_ovp_stop) else $error("gate high under hard ovp"); // R2

  property p_limit_blank;
    (q.state == ST_ON) && active && !s[IN_HOVP] && !s[IN_ONT] && !sc_trip
      && (q.blank < SHT_W'(LIMIT_BLANK_CYC)) |=> q.gate;
  endproperty
  a_limit_blank: assert property (p_limit_blank) else $error("pulse ended inside blanking"); // R4

  property p_sc_blank;
    (q.state == ST_ON) && s[IN_SC] && (q.blank >= SHT_W'(SHORT_BLANK_CYC)) |=> !q.gate;
  endproperty
  a_sc_blank: assert property (p_sc_blank) else $error("short-circuit trip did not end pulse"); // R5

  property p_sc_latch;
    s_sc_last_trip |=> s_latched_low [*4];
  endproperty
  a_sc_latch: assert property (p_sc_latch) else $error("fourth trip did not latch"); // R6

  property p_clean_clear;
    pulse_end && !sc_now |=> (q.sc_cnt == '0) && !q.wdog_ext;
  endproperty
  a_clean_clear: assert property (p_clean_clear) else $error("trip count not cleared"); // R7

  property p_wdog_restart;
    $rose(q.gate) |-> (q.wdog == '0) && (q.clamp != '0);
  endproperty
  a_wdog_restart: assert property (p_wdog_restart) else $error("pulse start timers wrong"); // R11

  property p_wdog_off;
    (s[IN_HOVP] || s[IN_FBSH]) && (q.state == ST_OFF) |=> (q.wdog == '0) && !q.gate;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("watchdog ran in ovp or short"); // R12

  property p_clamp_block;
    (q.clamp != '0) |=> !$rose(q.gate);
  endproperty
  a_clamp_block: assert property (p_clamp_block) else $error("pulse inside clamp period"); // R13

  property p_skip_start;
    !q.reached |-> !q.skip;
  endproperty
  a_skip_start: assert property (p_skip_start) else $error("skip before regulation"); // R20

  property p_fault_hold;
    q.fault |=> s_latched_low;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault released or gate high"); // R23

  property p_boost_on;
    $rose(active) |=> q.boost;
  endproperty
  a_boost_on: assert property (p_boost_on) else $error("boost pull-up late"); // R1

endmodule

// File: hw/pds_pkg.sv
// constants for the boost gate-drive sequencer: timing, register map, input indices
// assumes a single 100 MHz block clock and an AXI4-Lite register bus

package pds_pkg;

  // ***********************************************
  // clock and timing
  // ***********************************************
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CLK_KHZ          = 100000;
  localparam int unsigned LIMIT_BLANK_NS   = 325;
  localparam int unsigned SHORT_BLANK_NS   = 175;
  localparam int unsigned TOUT_US          = 10;
  localparam int unsigned WDOG_US          = 200;
  localparam int unsigned EXT_WDOG_MS      = 1;
  localparam int unsigned EN_FILT_US       = 100;
  localparam int unsigned DIS0_MS          = 500;
  localparam int unsigned DIS1_S           = 4;
  localparam int unsigned DIS2_S           = 13;
  localparam int unsigned MS_PER_S         = 1000;
  localparam int unsigned NS_PER_US        = 1000;
  localparam int unsigned CLAMP_LO_KHZ     = 131;
  localparam int unsigned CLAMP_HI_KHZ     = 250;
  localparam int unsigned LIMIT_BLANK_CYC  = (LIMIT_BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned SHORT_BLANK_CYC  = (SHORT_BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned TOUT_CYC         = TOUT_US * CLK_MHZ;
  localparam int unsigned CLAMP_LO_CYC     = (CLK_KHZ + CLAMP_LO_KHZ - 1) / CLAMP_LO_KHZ;
  localparam int unsigned CLAMP_HI_CYC     = (CLK_KHZ + CLAMP_HI_KHZ - 1) / CLAMP_HI_KHZ;
  localparam int unsigned SC_LIMIT         = 4;

  // ***********************************************
  // widths
  // ***********************************************
  localparam int unsigned CNT_W  = 31;
  localparam int unsigned SHT_W  = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SCC_W  = 3;
  localparam int unsigned CTRL_W = 4;

  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h04;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 4'h0;
  localparam int unsigned       CTRL_EN      = 0;
  localparam int unsigned       CTRL_CLAMP   = 1;
  localparam int unsigned       CTRL_DIS_LSB = 2;
  localparam logic [1:0]        RESP_OKAY    = 2'h0;
  localparam logic [1:0]        RESP_SLVERR  = 2'h2;

  // ***********************************************
  // comparator input indices
  // ***********************************************
  localparam int unsigned IN_HOVP   = 0;
  localparam int unsigned IN_OVPB   = 1;
  localparam int unsigned IN_REG    = 2;
  localparam int unsigned IN_FBSH   = 3;
  localparam int unsigned IN_ILIM   = 4;
  localparam int unsigned IN_SC     = 5;
  localparam int unsigned IN_ZARM   = 6;
  localparam int unsigned IN_ZTRIG  = 7;
  localparam int unsigned IN_ONT    = 8;
  localparam int unsigned IN_LLOW   = 9;
  localparam int unsigned IN_LHIGH  = 10;
  localparam int unsigned IN_SKLOW  = 11;
  localparam int unsigned IN_SKHIGH = 12;
  localparam int unsigned IN_UVP    = 13;
  localparam int unsigned IN_SSDONE = 14;
  localparam int unsigned N_IN      = 15;

endpackage

// File: test/pds_gate_model.sv
// gate driver and sense comparators at the far side of the sequencer
// assumes one block clock; outputs change just after the rising edge
`timescale 1ns/1ps
module pds_gate_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic boost_gate_drive,
  input  wire logic sc_mode,
  output logic      on_time_cmp,
  output logic      short_circuit_cmp,
  output logic      zero_cross_arm_cmp,
  output logic      zero_cross_trigger_cmp
);
  logic [9:0] n_q;
  logic       g_q;
  // count restarts at every gate edge and saturates so events never repeat
  always_ff @(posedge aclk) begin
    g_q <= aresetn && boost_gate_drive;
    n_q <= (!aresetn || g_q != boost_gate_drive) ? 10'h000 : n_q + (n_q != 10'h3FF);
    on_time_cmp <= g_q && n_q >= 10'h032;
    short_circuit_cmp <= sc_mode && g_q && n_q >= 10'h019;
    zero_cross_arm_cmp <= !g_q && n_q >= 10'h005 && n_q < 10'h014;
    zero_cross_trigger_cmp <= !g_q && n_q >= 10'h01E && n_q < 10'h028;
  end
endmodule

// File: test/tb_top.sv
// self-checking bench for the boost gate-drive sequencer
// assumes pds_gate_model answers every pulse with zero-cross events, and with on-time unless a short-circuit trip ends it first
`timescale 1ns/1ps
module tb_top;
  import pds_pkg::*;
  logic aclk = 0, aresetn = 0, sc_mode = 0, hard_ovp_cmp = 0, flyback_ss_done = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, soft_ovp_band_cmp = 0, regulation_cmp = 0, feedback_short_cmp = 0;
  logic current_limit_cmp = 0, load_low_cmp = 0, load_high_cmp = 0, skip_low_cmp = 0;
  logic skip_high_cmp = 0, undervoltage_cmp = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [1:0]  rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire boost_gate_drive, boost_pullup_en, soft_ovp_en, skip_active, stage_enabled, fault_latched;
  wire on_time_cmp, short_circuit_cmp, zero_cross_arm_cmp, zero_cross_trigger_cmp;
  int failures = 0, n_checks = 0, cyc = 0, pmin, pmax, wmax, rises, i, cl;
  // short watchdog and load timers keep the run brief
  pds_sequencer #(.WDOG_CYC(200), .EXT_CYC(400), .EN_FILT_CYC(50), .DIS0_CYC(100),
    .DIS1_CYC(200), .DIS2_CYC(300)) pds_sequencer_inst (.*);
  pds_gate_model pds_gate_model_inst (.*);
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end
  // ***************
  // tasks
  // ***************
  task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  // ready is read at the falling edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh;
    ah = 0;
    wh = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge aclk);
      ah = ah | s_axi_awready;
      wh = wh | s_axi_wready;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge aclk);
      ah = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!ah);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_arready;
      @(posedge aclk);
    end while (!ok);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!ok);
    s_axi_rready <= 1'b0;
  endtask
  // a pulse already high at the start is not counted as a rise
  task automatic watch(input int n);
    int last, hi, t;
    last = -1;
    hi = boost_gate_drive === 1'b1;
    rises = 0;
    pmin = 1 << 30;
    pmax = 0;
    wmax = 0;
    for (t = 0; t < n; t++) begin
      @(negedge aclk);
      hi = (boost_gate_drive === 1'b1) ? hi + 1 : 0;
      if (hi > wmax) wmax = hi;
      if (hi == 1) begin
        rises++;
        if (last >= 0 && t - last < pmin) pmin = t - last;
        if (last >= 0 && t - last > pmax) pmax = t - last;
        last = t;
      end
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ***************
  // tests
  // ***************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_b("stage_enabled", 1'b1, stage_enabled);
    cmp_b("gate", 1'b0, boost_gate_drive);
    axi_read(CTRL_OFS, rd, rs);
    cmp_w("ctrl", {28'h0, CTRL_RST}, rd);
    axi_read(8'h08, rd, rs);
    cmp_w("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      cl = i ? CLAMP_HI_CYC : CLAMP_LO_CYC;
      axi_write(CTRL_OFS, i ? 32'h3 : 32'h1, rs);
      cmp_w("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
      repeat (4) @(posedge aclk);
      cmp_b("pullup", 1'b1, boost_pullup_en);
      watch(6000);
      cmp_b("pulses", 1'b1, rises >= 2);
      cmp_b("clamp", 1'b1, pmin >= cl);
      cmp_b("timeout", 1'b1, pmax <= cl + TOUT_CYC + 8);
      cmp_b("on time", 1'b1, wmax >= 48 && wmax <= 60);
      $display("test clamp %0d done", i);
    end
    {hard_ovp_cmp, feedback_short_cmp} <= 2'b11;
    repeat (4) @(posedge aclk);
    watch(3000);
    cmp_w("ovp rises", 32'h0, rises);
    {hard_ovp_cmp, feedback_short_cmp} <= 2'b00;
    {sc_mode, current_limit_cmp} <= 2'b11;
    for (i = 0; i < 8000 && fault_latched !== 1'b1; i++) @(posedge aclk);
    cmp_b("fault", 1'b1, fault_latched);
    {flyback_ss_done, load_low_cmp} <= 2'b11;
    watch(2000);
    cmp_w("fault rises", 32'h0, rises);
    cmp_b("load off", 1'b0, stage_enabled);
    {load_low_cmp, load_high_cmp} <= 2'b01;
    repeat (80) @(posedge aclk);
    cmp_b("load on", 1'b1, stage_enabled);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_b("fault after reset", 1'b0, fault_latched);
    $display("test faults done");
    end_of_test();
  end
endmodule
